// ---- rtl/gotr_regbank.sv ----
// Gyro offset, temperature compensation and self-test register bank
`timescale 1ns/1ps

module gotr_regbank
  import gotr_pkg::*;
#(
  parameter int TC_FRAC = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port from the serial transport
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Factory trim
  input wire gotr_trim_t trim,
  // Raw gyro samples and temperature
  input wire gotr_sample_t sample,
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] temp_delta,
  // Corrected samples to the output registers
  output gotr_sample_t gyro_out,
  output logic gyro_out_valid,
  // Status
  output logic sleep_mode,
  output logic [2:0][5:0] noise_shift
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Signed compensation term from a sign-magnitude coefficient
  function automatic logic signed [17:0] tc_term(
    input logic [9:0] coeff,
    input logic signed [15:0] temp
  );
    logic signed [25:0] prod;
    logic signed [25:0] scaled;
    prod = $signed({1'b0, coeff[TC_SIGN_BIT-1:0]}) * temp;
    scaled = prod >>> TC_FRAC;
    tc_term = coeff[TC_SIGN_BIT] ? 18'(-scaled) : 18'(scaled);
  endfunction : tc_term

  // Clamp a wide sum into a sample
  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > SAMPLE_MAX) begin
      sat16 = SAMPLE_MAX[15:0];
    end else if (v < SAMPLE_MIN) begin
      sat16 = SAMPLE_MIN[15:0];
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // Sign-extend a sample
  function automatic logic signed [17:0] sx(input logic [15:0] v);
    sx = 18'($signed(v));
  endfunction : sx

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [2:0][7:0] tc_hi_q;
  logic [2:0][7:0] tc_lo_q;
  logic [2:0][7:0] st_q;
  logic [7:0] bias_hi_q;
  logic [7:0] bias_lo_q;
  logic [7:0] pwr_q;
  logic load_q;
  logic soft_rst;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;
  gotr_sample_t out_q;
  gotr_sample_t out_d;
  logic out_valid_q;
  logic [2:0][9:0] coeff;
  logic signed [15:0] bias;

  // Soft reset request from the power configuration register
  assign soft_rst = reg_wr && (reg_addr == A_PWR) &&
                    reg_wdata[PWR_SRST_BIT];

  // Trim load pending after reset or soft reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      load_q <= 1'b1;
    end else begin
      load_q <= soft_rst;
    end
  end

  // Compensation registers, trim load wins over a host write
  always_ff @(posedge mclk) begin
    if (rst) begin
      tc_hi_q <= '0;
      tc_lo_q <= '0;
    end else begin
      for (int a = 0; a < AXES; a++) begin
        if (load_q) begin
          tc_hi_q[a] <= trim.tc_high[a];
          tc_lo_q[a] <= trim.tc_low[a];
        end else if (reg_wr) begin
          if (reg_addr == A_TC_HI[a]) begin
            tc_hi_q[a] <= reg_wdata;
          end
          if (reg_addr == A_TC_LO[a]) begin
            tc_lo_q[a] <= reg_wdata;
          end
        end
      end
    end
  end

  // Self-test codes, factory values after any reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      for (int a = 0; a < AXES; a++) begin
        if (load_q) begin
          st_q[a] <= trim.selftest[a];
        end else if (reg_wr && (reg_addr == A_ST[a])) begin
          st_q[a] <= reg_wdata;
        end
      end
    end
  end

  // X user bias bytes
  always_ff @(posedge mclk) begin
    if (rst || soft_rst) begin
      bias_hi_q <= ZERO_BYTE;
      bias_lo_q <= ZERO_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == A_BIAS_HI) begin
        bias_hi_q <= reg_wdata;
      end
      if (reg_addr == A_BIAS_LO) begin
        bias_lo_q <= reg_wdata;
      end
    end
  end

  // Power configuration, asleep until the host changes it
  always_ff @(posedge mclk) begin
    if (rst || soft_rst) begin
      pwr_q <= PWR_RESET_VAL;
    end else if (reg_wr && (reg_addr == A_PWR)) begin
      pwr_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Registered read data, unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= ZERO_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= ZERO_BYTE;
        for (int a = 0; a < AXES; a++) begin
          if (reg_addr == A_TC_HI[a]) begin
            rdata_q <= tc_hi_q[a];
          end
          if (reg_addr == A_TC_LO[a]) begin
            rdata_q <= tc_lo_q[a];
          end
          if (reg_addr == A_ST[a]) begin
            rdata_q <= st_q[a];
          end
        end
        if (reg_addr == A_BIAS_HI) begin
          rdata_q <= bias_hi_q;
        end
        if (reg_addr == A_BIAS_LO) begin
          rdata_q <= bias_lo_q;
        end
        if (reg_addr == A_PWR) begin
          rdata_q <= {1'b0, pwr_q[PWR_SRST_BIT-1:0]};
        end
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample correction

  // Field extraction for coefficients and noise shifts
  always_comb begin
    for (int a = 0; a < AXES; a++) begin
      coeff[a] = {tc_hi_q[a][TC_HI_MSB:0], tc_lo_q[a]};
      noise_shift[a] = tc_hi_q[a][SHIFT_MSB:SHIFT_LSB];
    end
  end

  assign bias = $signed({bias_hi_q, bias_lo_q});

  // Compensation always applied, bias on X only
  always_comb begin
    for (int a = 0; a < AXES; a++) begin
      if (a == 0) begin
        out_d.axis[a] = sat16(sx(sample.axis[a]) + sx(bias) +
                              tc_term(coeff[a], temp_delta));
      end else begin
        out_d.axis[a] = sat16(sx(sample.axis[a]) +
                              tc_term(coeff[a], temp_delta));
      end
    end
  end

  // Output register, no samples while asleep
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= sample_valid && !pwr_q[PWR_SLEEP_BIT];
      if (sample_valid && !pwr_q[PWR_SLEEP_BIT]) begin
        out_q <= out_d;
      end
    end
  end

  assign gyro_out = out_q;
  assign gyro_out_valid = out_valid_q;
  assign sleep_mode = pwr_q[PWR_SLEEP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Magnitude product on Z at full width, for the sign check
  logic signed [25:0] z_prod_chk;
  assign z_prod_chk = $signed({1'b0, coeff[2][TC_SIGN_BIT-1:0]}) *
                      temp_delta;

  sequence reset_release_s;
    rst ##1 !rst [*2];
  endsequence

  sequence soft_reset_s;
    !rst && soft_rst ##1 !rst ##1 !rst;
  endsequence

  sequence bias_write_read_s;
    reg_wr && (reg_addr == A_BIAS_HI) ##1
      !rst && !soft_rst && !reg_wr ##1
      !rst && !soft_rst && reg_rd && (reg_addr == A_BIAS_HI);
  endsequence

  wake_from_reset_a: assert property (
    @(posedge mclk) $fell(rst) |-> sleep_mode && !gyro_out_valid)
    else $error("device not asleep after reset");

  sleep_no_output_a: assert property (
    @(posedge mclk) disable iff (rst)
    sleep_mode |=> !gyro_out_valid)
    else $error("sample produced while asleep");

  trim_load_a: assert property (
    @(posedge mclk) reset_release_s |->
      tc_hi_q == trim.tc_high && tc_lo_q == trim.tc_low)
    else $error("factory coefficients not loaded after reset");

  soft_restore_a: assert property (
    @(posedge mclk) soft_reset_s |->
      tc_hi_q == trim.tc_high && tc_lo_q == trim.tc_low &&
      st_q == trim.selftest && sleep_mode)
    else $error("soft reset did not restore trim");

  selftest_reset_a: assert property (
    @(posedge mclk) reset_release_s |-> st_q == trim.selftest)
    else $error("self-test codes not factory values after reset");

  bias_readback_a: assert property (
    @(posedge mclk) disable iff (rst)
    bias_write_read_s |=> reg_rvalid && reg_rdata == $past(reg_wdata, 3))
    else $error("bias high byte did not read back");

  zero_coeff_a: assert property (
    @(posedge mclk) disable iff (rst)
    sample_valid && !sleep_mode && coeff[1] == '0 |=>
      gyro_out_valid && gyro_out.axis[1] == $past(sample.axis[1]))
    else $error("zero coefficient changed the Y offset");

  bias_added_a: assert property (
    @(posedge mclk) disable iff (rst)
    sample_valid && !sleep_mode && coeff[0] == '0 |=>
      gyro_out_valid &&
      gyro_out.axis[0] == sat16(sx($past(sample.axis[0])) + sx($past(bias))))
    else $error("user bias not added to X sample");

  sign_flip_a: assert property (
    @(posedge mclk) disable iff (rst)
    sample_valid && !sleep_mode && coeff[2][TC_SIGN_BIT] |=>
      gyro_out.axis[2] == sat16(sx($past(sample.axis[2])) -
        18'($past(z_prod_chk) >>> TC_FRAC)))
    else $error("negative coefficient not subtracted on Z");

  tc_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    !load_q && reg_wr && reg_addr == A_X_TC_LO |=>
      tc_lo_q[0] == $past(reg_wdata))
    else $error("written coefficient not held");

  noise_field_a: assert property (
    @(posedge mclk) disable iff (rst)
    !load_q && reg_wr && reg_addr == A_Z_TC_HI |=>
      noise_shift[2] == $past(reg_wdata[SHIFT_MSB:SHIFT_LSB]))
    else $error("noise-mode shift field misplaced");

  unmapped_zero_a: assert property (
    @(posedge mclk) disable iff (rst)
    reg_rd && reg_addr == 7'h06 |=> reg_rvalid && reg_rdata == ZERO_BYTE)
    else $error("unmapped read not zero");

endmodule : gotr_regbank

// ---- shared/gotr_pkg.sv ----
// Package for the gyro offset and trim register bank
package gotr_pkg;

  // Register port, sample and sum widths, and axis count
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 16;
  localparam int SUM_W = 18;
  localparam int AXES = 3;

  // Register byte addresses
  localparam logic [6:0] A_X_TC_HI = 7'h04;
  localparam logic [6:0] A_X_TC_LO = 7'h05;
  localparam logic [6:0] A_Y_TC_HI = 7'h07;
  localparam logic [6:0] A_Y_TC_LO = 7'h08;
  localparam logic [6:0] A_Z_TC_HI = 7'h0a;
  localparam logic [6:0] A_Z_TC_LO = 7'h0b;
  localparam logic [6:0] A_ST_X = 7'h0d;
  localparam logic [6:0] A_ST_Y = 7'h0e;
  localparam logic [6:0] A_ST_Z = 7'h0f;
  localparam logic [6:0] A_BIAS_HI = 7'h13;
  localparam logic [6:0] A_BIAS_LO = 7'h14;
  localparam logic [6:0] A_PWR = 7'h6b;

  // Per-axis address tables, index 0 is X
  localparam logic [2:0][6:0] A_TC_HI = {A_Z_TC_HI, A_Y_TC_HI, A_X_TC_HI};
  localparam logic [2:0][6:0] A_TC_LO = {A_Z_TC_LO, A_Y_TC_LO, A_X_TC_LO};
  localparam logic [2:0][6:0] A_ST = {A_ST_Z, A_ST_Y, A_ST_X};

  // Power configuration layout and reset value
  localparam logic [7:0] PWR_RESET_VAL = 8'h41;
  localparam int PWR_SRST_BIT = 7;
  localparam int PWR_SLEEP_BIT = 6;

  // Field positions in the high compensation register, sign bit in the 10-bit coefficient
  localparam int SHIFT_MSB = 7;
  localparam int SHIFT_LSB = 2;
  localparam int TC_HI_MSB = 1;
  localparam int TC_SIGN_BIT = 9;

  // Saturation limits of a sample
  localparam logic signed [17:0] SAMPLE_MAX = 18'sh07fff;
  localparam logic signed [17:0] SAMPLE_MIN = 18'sh38000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Factory trim presented by the one-time store
  typedef struct packed {
    logic [2:0][7:0] tc_high;
    logic [2:0][7:0] tc_low;
    logic [2:0][7:0] selftest;
  } gotr_trim_t;

  // One gyro sample on three axes, index 0 is X
  typedef struct packed {
    logic [2:0][15:0] axis;
  } gotr_sample_t;

endpackage : gotr_pkg

// ---- verification/gotr_host_model.sv ----
// Host model driving the trim bank register port
`timescale 1ns/1ps

module gotr_host_model
  import gotr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register strobes toward the bank
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Idle port at time zero
  initial begin
    reg_addr = 7'h7f;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end

  // One byte strobe; host uses shifts and codes itself
  // Released lines show inverted values, not the last ones
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge mclk);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer

  // Expected self-test response in LSB for a stored code
  function automatic real st_response(input logic [7:0] code, input int fs);
    return (2620.0 / (2.0 ** fs)) * (1.01 ** (int'(code) - 1));
  endfunction : st_response
endmodule : gotr_host_model

// ---- verification/testbench.sv ----
// Self-checking bench for the gyro trim register bank
`timescale 1ns/1ps

module testbench;
  import gotr_pkg::*;
  localparam int FR = 8;
  logic mclk, rst, reg_wr, reg_rd, reg_rvalid, sample_valid;
  logic gyro_out_valid, sleep_mode, awake;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic signed [15:0] temp_delta;
  logic [2:0][5:0] noise_shift;
  logic [95:0] rnd;
  gotr_trim_t trim;
  gotr_sample_t sample, gyro_out;
  logic [7:0] shadow [int];
  logic [7:0] rq [$];
  gotr_sample_t sq [$];
  int errors = 0;
  int checks_done = 0;
  logic [6:0] amap [13] = '{7'h04, 7'h05, 7'h07, 7'h08, 7'h0a, 7'h0b,
    7'h0d, 7'h0e, 7'h0f, 7'h13, 7'h14, 7'h6b, 7'h06};

  // Bank and host
  gotr_regbank #(.TC_FRAC(FR)) dut (.mclk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .trim, .sample,
    .sample_valid, .temp_delta, .gyro_out, .gyro_out_valid, .sleep_mode,
    .noise_shift);
  gotr_host_model u_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  // Bench clock
  initial mclk = 1'h0;
  always #20 mclk = ~mclk;

  //////////////////////////////////////////////////////////////////////////
  // Comparisons and verdict
  task automatic ck8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t byte %h exp %h", $time, g, e);
    end
  endtask : ck8

  task automatic cks(input gotr_sample_t g, input gotr_sample_t e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t sample %h exp %h", $time, g, e);
    end
  endtask : cks

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Pop the oldest note whenever a result shows
  always @(negedge mclk) begin
    if (reg_rvalid !== 1'h0)
      ck8(reg_rdata, rq.size() ? rq.pop_front() : 8'hxx);
    if (gyro_out_valid !== 1'h0)
      cks(gyro_out, sq.size() ? sq.pop_front() : 'x);
  end

  // Expected corrected sample of one axis, saturated to 16 bits
  function automatic logic [15:0] expo(input int a, input logic [15:0] s,
                                       input logic [15:0] t);
    logic [9:0] c;
    longint p;
    longint v;
    c = {shadow[A_TC_HI[a]][1:0], shadow[A_TC_LO[a]]};
    p = (longint'(c[8:0]) * longint'($signed(t))) >>> FR;
    if (c[9])
      p = -p;
    v = longint'($signed(s)) + p;
    if (a == 0)
      v += longint'($signed({shadow[A_BIAS_HI], shadow[A_BIAS_LO]}));
    if (v > 32767)
      v = 32767;
    if (v < -32768)
      v = -32768;
    return v[15:0];
  endfunction : expo

  //////////////////////////////////////////////////////////////////////////
  // Register and sample drivers
  task automatic rd(input logic [6:0] a);
    rq.push_back(shadow.exists(a) ? shadow[a] : 8'h00);
    u_host.xfer(1'h0, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'h1, a, d);
    shadow[a] = d;
  endtask : wr

  task automatic load_trim();
    for (int i = 0; i < 3; i++) begin
      shadow[A_TC_HI[i]] = trim.tc_high[i];
      shadow[A_TC_LO[i]] = trim.tc_low[i];
      shadow[A_ST[i]] = trim.selftest[i];
    end
    shadow[A_BIAS_HI] = 8'h00;
    shadow[A_BIAS_LO] = 8'h00;
    shadow[A_PWR] = PWR_RESET_VAL;
    awake = 1'h0;
  endtask : load_trim

  task automatic check_all();
    foreach (amap[i]) rd(amap[i]);
    ck8({7'h00, sleep_mode}, {7'h00, !awake});
  endtask : check_all

  task automatic smp();
    gotr_sample_t s, e;
    logic [15:0] t;
    rnd = {$urandom(), $urandom(), $urandom()};
    s = rnd[47:0];
    t = rnd[63:48];
    for (int a = 0; a < 3; a++) e.axis[a] = expo(a, s.axis[a], t);
    @(negedge mclk);
    sample = s;
    temp_delta = t;
    sample_valid = 1'h1;
    if (awake)
      sq.push_back(e);
    @(negedge mclk);
    sample_valid = 1'h0;
  endtask : smp

  // Main sequence
  initial begin
    void'($urandom(32'he2970371));
    rst = 1'h1;
    sample = '0;
    sample_valid = 1'h0;
    temp_delta = 16'h0000;
    rnd = {$urandom(), $urandom(), $urandom()};
    trim = rnd[71:0];
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'h0;
    load_trim();
    check_all();
    smp();
    for (int i = 0; i < 11; i++) wr(amap[i], 8'($urandom()));
    check_all();
    for (int i = 0; i < 3; i++)
      ck8({2'h0, noise_shift[i]}, {2'h0, shadow[A_TC_HI[i]][7:2]});
    wr(A_BIAS_HI, 8'($urandom()));
    rd(A_BIAS_HI);
    wr(A_PWR, 8'h01);
    awake = 1'h1;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6; i++) wr(amap[i], k ? 8'($urandom()) : 8'h00);
      repeat (4) smp();
    end
    wr(A_PWR, 8'h80);
    load_trim();
    check_all();
    repeat (4) @(negedge mclk);
    ck8(8'(rq.size() + sq.size()), 8'h00);
    report_and_stop();
  end

  // Cut a hang short well past the expected run
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule : testbench
